//--- rtl/act_timing.v
// conversion timing generator, mode decode and avalon register slave
`timescale 1ns/1ps
`include "act_defs.vh"

// one counter stage: count down per tick, pulse and reload on expiry
module act_count #(
  parameter W = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire run,
  input wire tick,
  input wire [W-1:0] load_val,
  // state
  output reg [W-1:0] cnt_r,
  output reg expire_r
);
  // zero means idle; first tick after run only loads
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (!run) begin
        cnt_r <= {W{1'b0}};
      end else if (tick) begin
        if (cnt_r == {W{1'b0}}) begin
          cnt_r <= load_val;
        end else if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
          cnt_r <= load_val;
          expire_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // act_count

module act_timing #(
  parameter PW = 8,
  parameter DW = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // mode pins
  input wire aux_data_or_mode_pin,
  input wire fsd_wb_in,
  output reg fsd_wb_out,
  output reg fsd_wb_oe_n,
  // serial port state from the frame logic
  input wire primary_active,
  input wire secondary_active,
  input wire adc_result_busy,
  input wire frame_done,
  input wire adc_bit,
  input wire aux_bit,
  // timing and frame outputs
  output reg shift_clk,
  output reg dac_filter_clock,
  output reg adc_filter_clock,
  output reg dac_conv,
  output reg adc_conv,
  output reg receive_frame_sync_n,
  output reg serial_receive_line,
  output reg end_of_transmit_strobe_n,
  output reg end_of_receive_strobe_n,
  output reg [1:0] mode,
  output reg sync_mode
);
  reg [PW-1:0] dac_prescale_value_r;
  reg [PW-1:0] dac_adjust_value_r;
  reg [DW-1:0] dac_divisor_value_r;
  reg [PW-1:0] adc_prescale_value_r;
  reg [PW-1:0] adc_adjust_value_r;
  reg [DW-1:0] adc_divisor_value_r;
  reg sync_select_bit_r;
  reg [1:0] dac_adj_r;
  reg [1:0] adc_adj_r;
  reg [1:0] shift_cnt_r;
  reg dac_filt_r;
  reg adc_filt_r;
  reg dual_r;
  reg armed_r;
  reg [2:0] eod_cnt_r;
  reg [31:0] rd_nxt;
  reg [PW-1:0] dac_load_nxt;
  reg [PW-1:0] adc_load_nxt;
  wire [PW-1:0] dac_s1_cnt;
  wire [DW-1:0] dac_s2_cnt;
  wire [PW-1:0] adc_s1_cnt;
  wire [DW-1:0] adc_s2_cnt;
  wire dac_s1_exp;
  wire dac_s2_exp;
  wire adc_s1_exp;
  wire adc_s2_exp;
  wire wr_go;
  wire [PW-1:0] one_p;
  wire dac_bound;
  wire adc_bound;
  wire async_run;
  wire word_pin;

  assign one_p = {{(PW-1){1'b0}}, 1'b1};
  assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign async_run = !sync_select_bit_r;
  // next first-stage reload starts a new conversion period
  assign dac_bound = (dac_s2_cnt == {{(DW-1){1'b0}}, 1'b1}) && !dac_filt_r;
  assign adc_bound = (adc_s2_cnt == {{(DW-1){1'b0}}, 1'b1}) && !adc_filt_r;
  assign word_pin = fsd_wb_in;

  // first-stage reload value; adjusted only at a period boundary
  always @* begin
    dac_load_nxt = dac_prescale_value_r;
    adc_load_nxt = adc_prescale_value_r;
    if (dac_bound && dac_adj_r == `ACT_ADJ_MINUS) begin
      // clamp so the stage never loads zero and stalls
      if (dac_prescale_value_r > dac_adjust_value_r) begin
        dac_load_nxt = dac_prescale_value_r - dac_adjust_value_r;
      end else begin
        dac_load_nxt = one_p;
      end
    end else if (dac_bound && dac_adj_r == `ACT_ADJ_PLUS) begin
      // saturates instead of wrapping to a short period
      if (dac_prescale_value_r > ~dac_adjust_value_r) begin
        dac_load_nxt = {PW{1'b1}};
      end else begin
        dac_load_nxt = dac_prescale_value_r + dac_adjust_value_r;
      end
    end
    if (adc_bound && adc_adj_r == `ACT_ADJ_MINUS) begin
      if (adc_prescale_value_r > adc_adjust_value_r) begin
        adc_load_nxt = adc_prescale_value_r - adc_adjust_value_r;
      end else begin
        adc_load_nxt = one_p;
      end
    end else if (adc_bound && adc_adj_r == `ACT_ADJ_PLUS) begin
      if (adc_prescale_value_r > ~adc_adjust_value_r) begin
        adc_load_nxt = {PW{1'b1}};
      end else begin
        adc_load_nxt = adc_prescale_value_r + adc_adjust_value_r;
      end
    end
    if (dac_load_nxt == {PW{1'b0}}) begin
      dac_load_nxt = one_p;
    end
    if (adc_load_nxt == {PW{1'b0}}) begin
      adc_load_nxt = one_p;
    end
  end

  // dac path: first stage on every mclk, second on filter clock rise
  act_count #(.W(PW)) u_dac_s1 (
    .mclk(mclk), .rst(rst), .run(1'b1), .tick(1'b1),
    .load_val(dac_load_nxt), .cnt_r(dac_s1_cnt), .expire_r(dac_s1_exp)
  );
  act_count #(.W(DW)) u_dac_s2 (
    .mclk(mclk), .rst(rst), .run(1'b1), .tick(dac_s1_exp && !dac_filt_r),
    .load_val(dac_divisor_value_r),
    .cnt_r(dac_s2_cnt), .expire_r(dac_s2_exp)
  );
  // adc path runs only when asynchronous
  act_count #(.W(PW)) u_adc_s1 (
    .mclk(mclk), .rst(rst), .run(async_run), .tick(1'b1),
    .load_val(adc_load_nxt), .cnt_r(adc_s1_cnt), .expire_r(adc_s1_exp)
  );
  act_count #(.W(DW)) u_adc_s2 (
    .mclk(mclk), .rst(rst), .run(async_run), .tick(adc_s1_exp && !adc_filt_r),
    .load_val(adc_divisor_value_r),
    .cnt_r(adc_s2_cnt), .expire_r(adc_s2_exp)
  );

  // filter clocks toggle per first-stage expiry: mclk / (2 * prescale)
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_filt_r <= 1'b0;
      adc_filt_r <= 1'b0;
    end else begin
      if (dac_s1_exp) begin
        dac_filt_r <= !dac_filt_r;
      end
      if (!async_run) begin
        adc_filt_r <= 1'b0;
      end else if (adc_s1_exp) begin
        adc_filt_r <= !adc_filt_r;
      end
    end
  end

  // timing outputs; sync mode feeds the adc side from the dac chain
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_filter_clock <= 1'b0;
      adc_filter_clock <= 1'b0;
      dac_conv <= 1'b0;
      adc_conv <= 1'b0;
    end else begin
      dac_filter_clock <= dac_filt_r;
      dac_conv <= dac_s2_exp;
      if (sync_select_bit_r) begin
        adc_filter_clock <= dac_filt_r;
        adc_conv <= dac_s2_exp;
      end else begin
        adc_filter_clock <= adc_filt_r;
        adc_conv <= adc_s2_exp;
      end
    end
  end

  // shift clock: high for two mclk, low for two; high in reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_cnt_r <= 2'h0;
      shift_clk <= 1'b1;
    end else begin
      shift_cnt_r <= shift_cnt_r + 2'h1;
      shift_clk <= (shift_cnt_r >= `ACT_SHIFT_HALF) ? 1'b0 : 1'b1;
      if (shift_cnt_r == 2'h3) begin
        shift_clk <= 1'b1;
      end
    end
  end

  // mode strap: dual word is fixed by what drives the pin at release
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
      dual_r <= 1'b0;
    end else if (!armed_r) begin
      armed_r <= 1'b1;
      dual_r <= aux_data_or_mode_pin;
    end
  end

  // mode outputs and the shared pin direction
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= `ACT_MODE_WORD;
      sync_mode <= `ACT_RST_SYNC;
      fsd_wb_oe_n <= 1'b1;
    end else begin
      sync_mode <= sync_select_bit_r;
      if (dual_r) begin
        mode <= `ACT_MODE_DUAL;
        fsd_wb_oe_n <= 1'b0;
      end else begin
        mode <= word_pin ? `ACT_MODE_WORD : `ACT_MODE_BYTE;
        fsd_wb_oe_n <= 1'b1;
      end
    end
  end

  // secondary strobe, receive sync and receive line routing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fsd_wb_out <= 1'b1;
      receive_frame_sync_n <= 1'b1;
      serial_receive_line <= 1'b0;
    end else begin
      fsd_wb_out <= 1'b1;
      receive_frame_sync_n <= !primary_active;
      serial_receive_line <= adc_bit;
      // a busy receive line in async mode blocks the secondary slot
      if (dual_r && secondary_active &&
          !(async_run && adc_result_busy)) begin
        fsd_wb_out <= 1'b0;
        serial_receive_line <= aux_bit;
      end
      if (secondary_active) begin
        receive_frame_sync_n <= 1'b1;
      end
    end
  end

  // end strobes: one shift clock low after each transfer outside dual mode
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      eod_cnt_r <= 3'h0;
      end_of_transmit_strobe_n <= 1'b1;
      end_of_receive_strobe_n <= 1'b1;
    end else begin
      if (frame_done && !dual_r) begin
        eod_cnt_r <= `ACT_SHIFT_DIV;
      end else if (eod_cnt_r != 3'h0) begin
        eod_cnt_r <= eod_cnt_r - 3'h1;
      end
      end_of_transmit_strobe_n <= !((frame_done && !dual_r) ||
                                    eod_cnt_r > 3'h1);
      end_of_receive_strobe_n <= !((frame_done && !dual_r) ||
                                   eod_cnt_r > 3'h1);
    end
  end

  // register writes; a new adjust command beats the reload that clears it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_prescale_value_r <= `ACT_RST_PRESCALE;
      dac_adjust_value_r <= `ACT_RST_ADJUST;
      dac_divisor_value_r <= `ACT_RST_DIVISOR;
      adc_prescale_value_r <= `ACT_RST_PRESCALE;
      adc_adjust_value_r <= `ACT_RST_ADJUST;
      adc_divisor_value_r <= `ACT_RST_DIVISOR;
      sync_select_bit_r <= `ACT_RST_SYNC;
      dac_adj_r <= `ACT_ADJ_NONE;
      adc_adj_r <= `ACT_ADJ_NONE;
    end else begin
      if (dac_bound && dac_s1_cnt == one_p) begin
        dac_adj_r <= `ACT_ADJ_NONE;
      end
      if (adc_bound && adc_s1_cnt == one_p) begin
        adc_adj_r <= `ACT_ADJ_NONE;
      end
      if (wr_go) begin
        case (avs_address)
          `ACT_OFS_DAC_PRESCALE: dac_prescale_value_r <= avs_writedata[PW-1:0];
          `ACT_OFS_DAC_ADJUST: dac_adjust_value_r <= avs_writedata[PW-1:0];
          `ACT_OFS_DAC_DIVISOR: dac_divisor_value_r <= avs_writedata[DW-1:0];
          `ACT_OFS_ADC_PRESCALE: adc_prescale_value_r <= avs_writedata[PW-1:0];
          `ACT_OFS_ADC_ADJUST: adc_adjust_value_r <= avs_writedata[PW-1:0];
          `ACT_OFS_ADC_DIVISOR: adc_divisor_value_r <= avs_writedata[DW-1:0];
          `ACT_OFS_CONTROL: begin
            sync_select_bit_r <= avs_writedata[`ACT_CTL_SYNC];
            dac_adj_r <= avs_writedata[`ACT_CTL_DAC_ADJ_LO +: 2];
            adc_adj_r <= avs_writedata[`ACT_CTL_ADC_ADJ_LO +: 2];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rd_nxt = 32'h0;
    case (avs_address)
      `ACT_OFS_DAC_PRESCALE: rd_nxt[PW-1:0] = dac_prescale_value_r;
      `ACT_OFS_DAC_ADJUST: rd_nxt[PW-1:0] = dac_adjust_value_r;
      `ACT_OFS_DAC_DIVISOR: rd_nxt[DW-1:0] = dac_divisor_value_r;
      `ACT_OFS_ADC_PRESCALE: rd_nxt[PW-1:0] = adc_prescale_value_r;
      `ACT_OFS_ADC_ADJUST: rd_nxt[PW-1:0] = adc_adjust_value_r;
      `ACT_OFS_ADC_DIVISOR: rd_nxt[DW-1:0] = adc_divisor_value_r;
      `ACT_OFS_CONTROL: begin
        rd_nxt[`ACT_CTL_SYNC] = sync_select_bit_r;
        rd_nxt[`ACT_CTL_DAC_ADJ_LO +: 2] = dac_adj_r;
        rd_nxt[`ACT_CTL_ADC_ADJ_LO +: 2] = adc_adj_r;
      end
      `ACT_OFS_STATUS: begin
        rd_nxt[0] = sync_mode;
        rd_nxt[2:1] = mode;
        rd_nxt[15:8] = dac_s2_cnt[7:0];
        rd_nxt[23:16] = adc_s2_cnt[7:0];
      end
      default: rd_nxt = 32'h0;
    endcase
  end

  // one wait cycle per access; data stands while waitrequest is low
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_nxt;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
endmodule // act_timing

//--- rtl/act_defs.vh
// constants for the conversion timing block
`ifndef ACT_DEFS_VH
`define ACT_DEFS_VH
// register byte offsets
`define ACT_OFS_DAC_PRESCALE 5'h00
`define ACT_OFS_DAC_ADJUST 5'h04
`define ACT_OFS_DAC_DIVISOR 5'h08
`define ACT_OFS_ADC_PRESCALE 5'h0c
`define ACT_OFS_ADC_ADJUST 5'h10
`define ACT_OFS_ADC_DIVISOR 5'h14
`define ACT_OFS_CONTROL 5'h18
`define ACT_OFS_STATUS 5'h1c
// reset values: 16 kHz conversion from a 10.368 MHz master clock
`define ACT_RST_PRESCALE 8'h12
`define ACT_RST_ADJUST 8'h01
`define ACT_RST_DIVISOR 8'h12
`define ACT_RST_SYNC 1'b1
// control field positions
`define ACT_CTL_SYNC 0
`define ACT_CTL_DAC_ADJ_LO 1
`define ACT_CTL_ADC_ADJ_LO 3
// adjust choices
`define ACT_ADJ_NONE 2'h0
`define ACT_ADJ_MINUS 2'h1
`define ACT_ADJ_PLUS 2'h2
// operating modes
`define ACT_MODE_BYTE 2'h0
`define ACT_MODE_WORD 2'h1
`define ACT_MODE_DUAL 2'h2
// master clocks per shift clock, and the count from which it goes low
`define ACT_SHIFT_DIV 3'h4
`define ACT_SHIFT_HALF 2'h1
`endif

//--- test/act_timing_props.sv
// assertion checker for the conversion timing block
`timescale 1ns/1ps
`include "act_defs.vh"
module act_timing_props (
  // clock and reset
  input wire mclk,
  input wire rst,
  // frame side
  input wire primary_active,
  input wire secondary_active,
  input wire adc_result_busy,
  input wire frame_done,
  // timing and strobes
  input wire shift_clk,
  input wire dac_conv,
  input wire adc_conv,
  input wire dac_filter_clock,
  input wire adc_filter_clock,
  input wire fsd_wb_out,
  input wire receive_frame_sync_n,
  input wire end_of_transmit_strobe_n,
  input wire end_of_receive_strobe_n,
  input wire [1:0] mode,
  input wire sync_mode,
  // receive line routing and pin direction
  input wire adc_bit,
  input wire aux_bit,
  input wire serial_receive_line,
  input wire fsd_wb_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // reset itself is the cause here, so no disable
  shift_hold_a: assert property (disable iff (1'b0)
    rst |-> shift_clk) else $error("shift clock low in reset");
  shift_div_a: assert property (
    $rose(shift_clk) |=> shift_clk ##1 !shift_clk [*2] ##1 shift_clk)
    else $error("shift clock not master clock over four");
  conv_pulse_a: assert property (
    dac_conv |=> !dac_conv) else $error("conversion pulse too long");
  // settle two cycles after a mode write before comparing the chains
  sync_share_a: assert property (
    sync_mode && $past(sync_mode) && $past(sync_mode, 2) |->
    adc_conv == dac_conv && adc_filter_clock == dac_filter_clock)
    else $error("sync mode timing not shared");
  // sync_mode lags the control bit, so confirm it one cycle later
  sec_low_a: assert property (
    (mode == `ACT_MODE_DUAL && secondary_active &&
    (sync_mode || !adc_result_busy)) ##1 $stable(sync_mode) |-> !fsd_wb_out)
    else $error("secondary strobe not low");
  prim_high_a: assert property (
    mode == `ACT_MODE_DUAL && primary_active |=> fsd_wb_out)
    else $error("secondary strobe low in primary");
  rfs_quiet_a: assert property (
    secondary_active |=> receive_frame_sync_n)
    else $error("receive sync asserted in secondary");
  busy_high_a: assert property (
    (mode == `ACT_MODE_DUAL && !sync_mode && adc_result_busy) ##1
    !sync_mode |-> fsd_wb_out)
    else $error("secondary strobe low while receive line busy");
  route_aux_a: assert property (
    !fsd_wb_out |-> serial_receive_line == $past(aux_bit))
    else $error("aux data not routed to receive line");
  route_adc_a: assert property (
    fsd_wb_out |-> serial_receive_line == $past(adc_bit))
    else $error("receive line not carrying converter data");
  pin_dir_a: assert property (
    fsd_wb_oe_n == (mode != `ACT_MODE_DUAL))
    else $error("shared pin direction wrong for mode");
  eod_pair_a: assert property (
    end_of_receive_strobe_n == end_of_transmit_strobe_n)
    else $error("end strobes differ");
  eod_pulse_a: assert property (
    mode != `ACT_MODE_DUAL && frame_done |=>
    !end_of_transmit_strobe_n [*4] ##1 end_of_transmit_strobe_n)
    else $error("end of transmit pulse wrong");
  dual_noeod_a: assert property (
    mode == `ACT_MODE_DUAL |->
    end_of_transmit_strobe_n && end_of_receive_strobe_n)
    else $error("end strobes pulse in dual mode");
  c_conv: cover property (dac_conv);
  c_sec: cover property (mode == `ACT_MODE_DUAL && !fsd_wb_out);
  c_eod: cover property (!end_of_receive_strobe_n);
  c_async: cover property (!sync_mode && adc_conv);
endmodule // act_timing_props

bind act_timing act_timing_props act_timing_props_i (.mclk, .rst,
  .primary_active, .secondary_active, .adc_result_busy, .frame_done,
  .shift_clk, .dac_conv, .adc_conv, .dac_filter_clock, .adc_filter_clock,
  .fsd_wb_out, .receive_frame_sync_n, .end_of_transmit_strobe_n,
  .end_of_receive_strobe_n, .mode, .sync_mode, .adc_bit, .aux_bit,
  .serial_receive_line, .fsd_wb_oe_n);

//--- test/act_dsp_port.sv
// behavioural frame-side model driving the serial port status lines
`timescale 1ns/1ps
module act_dsp_port (
  // clock and reset
  input wire mclk,
  input wire rst,
  // scenario control
  input wire busy_en,
  // frame activity
  output wire primary_active,
  output wire secondary_active,
  output wire adc_result_busy,
  output wire frame_done,
  output wire adc_bit,
  output wire aux_bit
);
  logic [5:0] pos_r;
  // one 64-cycle frame, long enough for the end strobes to finish
  always @(posedge mclk or posedge rst) begin
    if (rst)
      pos_r <= 6'h00;
    else
      pos_r <= pos_r + 6'h01;
  end
  assign primary_active = pos_r < 6'h10;
  assign frame_done = pos_r == 6'h10;
  // secondary slot overlaps the busy window to provoke the conflict
  assign secondary_active = pos_r >= 6'h1c && pos_r < 6'h2c;
  assign adc_result_busy = busy_en && pos_r >= 6'h14 && pos_r < 6'h28;
  // adc_bit toggles every cycle so a stale value never looks right; aux_bit toggles only every second cycle
  assign adc_bit = pos_r[0];
  assign aux_bit = ~pos_r[1];
endmodule // act_dsp_port

//--- test/act_timing_bench.sv
// self-checking bench for the conversion timing block
`timescale 1ns/1ps
`include "act_defs.vh"
module act_timing_bench;
  // rst starts low so the first assertion is a real async reset edge
  logic mclk = 0, rst = 0, avs_read = 0, avs_write = 0;
  logic [4:0] avs_address = 0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 0;
  logic strap = 0, wb_lvl = 1, busy_en = 0;
  wire [31:0] avs_readdata;
  wire [1:0] mode;
  wire avs_waitrequest, fsd_wb_in, fsd_wb_out, fsd_wb_oe_n;
  wire primary_active, secondary_active, adc_result_busy, frame_done;
  wire adc_bit, aux_bit, shift_clk, dac_filter_clock, adc_filter_clock;
  wire dac_conv, adc_conv, receive_frame_sync_n, serial_receive_line;
  wire end_of_transmit_strobe_n, end_of_receive_strobe_n, sync_mode;
  int n_errors = 0, comparisons = 0, cyc = 0, seed = 91;
  // 125 MHz / (2 * 217) is about 288 kHz of filter clock
  localparam int F288_PRE = 217;
  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // pin follows the device while it drives, else the strap level
  assign fsd_wb_in = fsd_wb_oe_n ? wb_lvl : fsd_wb_out;
  act_timing act_timing_i (.mclk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .aux_data_or_mode_pin(strap), .fsd_wb_in,
    .fsd_wb_out, .fsd_wb_oe_n, .primary_active, .secondary_active,
    .adc_result_busy, .frame_done, .adc_bit, .aux_bit, .shift_clk,
    .dac_filter_clock, .adc_filter_clock, .dac_conv, .adc_conv,
    .receive_frame_sync_n, .serial_receive_line,
    .end_of_transmit_strobe_n, .end_of_receive_strobe_n, .mode,
    .sync_mode);
  act_dsp_port act_dsp_port_i (.mclk, .rst, .busy_en, .primary_active,
    .secondary_active, .adc_result_busy, .frame_done, .adc_bit, .aux_bit);
  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %0t period got %0d exp %0d", $time, got, exp);
    end
  endtask
  // one access, then an idle cycle so no strobe is set twice at one edge
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge mclk);
    if (n >= 100) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, 4'hf, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(0, a, 32'h0, 4'hf, q);
    chk_reg(q, exp);
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return dac_conv;
      1: return adc_conv;
      2: return dac_filter_clock;
      default: return shift_clk;
    endcase
  endfunction
  // cycle stamp of the next rising edge of a chosen timing output
  task automatic rise(input int k, output int t);
    int n;
    n = 0;
    do @(posedge mclk); while (sel(k) !== 1'b0 && ++n < 3000);
    do @(posedge mclk); while (sel(k) !== 1'b1 && ++n < 3000);
    t = cyc;
    if (n >= 3000) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic per(input int k, input int exp);
    int t0, t1;
    rise(k, t0);
    rise(k, t0);
    rise(k, t1);
    chk_time(t1 - t0, exp);
  endtask
  // one-shot adjust: three periods span exactly one altered reload
  task automatic adj(input int k, input int c, input int prd, input int a);
    int t0, t1;
    rise(k, t0);
    wr(`ACT_OFS_CONTROL, k ? 32'(c << 3) : 32'(1 | c << 1));
    repeat (3) rise(k, t1);
    chk_time(t1 - t0, 3 * prd + (c == 1 ? -a : c == 2 ? a : 0));
    rdc(`ACT_OFS_CONTROL, k ? 32'h0 : 32'h1);
  endtask
  initial begin
    int p, d, q, e, a, m, c;
    logic [31:0] r;
    logic [7:0] rv [7];
    rv = '{`ACT_RST_PRESCALE, `ACT_RST_ADJUST, `ACT_RST_DIVISOR,
      `ACT_RST_PRESCALE, `ACT_RST_ADJUST, `ACT_RST_DIVISOR, 8'h01};
    for (m = 0; m < 3; m++) begin
      strap <= (m == 2);
      wb_lvl <= (m != 1);
      busy_en <= 0;
      rst <= 1;
      repeat (10) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      bus(0, `ACT_OFS_STATUS, 32'h0, 4'hf, r);
      chk_reg(r[2:0], {m == 2 ? `ACT_MODE_DUAL : m == 1 ?
        `ACT_MODE_BYTE : `ACT_MODE_WORD, 1'b1});
      if (m == 0) begin
        for (c = 0; c < 7; c++)
          rdc(5'(c * 4), 32'(rv[c]));
        rdc(5'h02, 32'h0);
        bus(1, `ACT_OFS_DAC_PRESCALE, 32'h7, 4'he, r);
        rdc(`ACT_OFS_DAC_PRESCALE, 32'h12);
        per(3, 4);
        wr(`ACT_OFS_DAC_PRESCALE, F288_PRE);
        per(2, 2 * F288_PRE);
        p = 3 + $unsigned($random(seed)) % 4;
        d = 2 + $unsigned($random(seed)) % 3;
        q = 3 + $unsigned($random(seed)) % 4;
        e = 2 + $unsigned($random(seed)) % 3;
        a = 1 + $unsigned($random(seed)) % 2;
        wr(`ACT_OFS_DAC_PRESCALE, p);
        wr(`ACT_OFS_DAC_DIVISOR, d);
        wr(`ACT_OFS_ADC_PRESCALE, q);
        wr(`ACT_OFS_ADC_DIVISOR, e);
        wr(`ACT_OFS_DAC_ADJUST, a);
        wr(`ACT_OFS_ADC_ADJUST, a);
        per(2, 2 * p);
        per(0, 2 * p * d);
        per(1, 2 * p * d);
        for (c = 1; c < 4; c++)
          adj(0, c, 2 * p * d, a);
        wr(`ACT_OFS_CONTROL, 32'h0);
        per(1, 2 * q * e);
        for (c = 1; c < 4; c++)
          adj(1, c, 2 * q * e, a);
        wr(`ACT_OFS_CONTROL, 32'h1);
      end
      repeat (200) @(posedge mclk);
      wr(`ACT_OFS_CONTROL, 32'h0);
      busy_en <= 1;
      repeat (300) @(posedge mclk);
    end
    test_done;
  end
endmodule // act_timing_bench
